// *** hw/usp_cfg.svh ***
`ifndef USP_CFG_SVH
`define USP_CFG_SVH

// register byte offsets on the apb bus
`define USP_OFF_CTRL   12'h000
`define USP_OFF_ENA    12'h004
`define USP_OFF_FLAGS  12'h008
`define USP_OFF_STAT   12'h00C
`define USP_OFF_DIV    12'h010
`define USP_OFF_TXBUF  12'h014
`define USP_OFF_RXBUF  12'h018

// control register fields
`define USP_CTL_SOFT_RESET_BIT  0
`define USP_CTL_MM     1
`define USP_CTL_SYNC   2
`define USP_CTL_I2C    3
`define USP_CTL_CHAR   4
`define USP_CTL_FOUR   5
`define USP_CTL_POL    6
`define USP_CTL_PHA    7
`define USP_CTL_RESET  8'h01

// enable register fields
`define USP_ENA_ME     0
`define USP_ENA_RXIE   1
`define USP_ENA_TXIE   2
`define USP_ENA_RESET  3'h0

// second serial interrupt flag register fields
`define USP_FLG_TX     5
`define USP_FLG_RX     4
`define USP_FLG_RESET  8'h20

// status register fields
`define USP_STA_TRANSMITTER_EMPTY_BIT  0
`define USP_STA_OVR    1
`define USP_STA_BCE    2

// divisor floor keeps the bit clock at or below half the source
`define USP_DIV_MIN    16'h0002
`define USP_DIV_RESET  16'h0002

`endif

// *** hw/usp_pkg.sv ***
package usp_pkg;
   typedef enum logic [1:0] {
      USP_IDLE = 2'b01,
      USP_XFER = 2'b10
   } usp_state_t;

   typedef logic [7:0] usp_byte_t;
endpackage : usp_pkg

// *** hw/usp_spi.sv ***
// Overview of operation
// - spi mode only when clocked-serial select is one and two-wire select zero.
// - character length seven or eight bits, chosen by a control bit.
// - master drives out line and clock, samples in line; slave the reverse.
// - 4-pin master with enable pin low releases out line and clock.
// - 4-pin master with enable pin low sets the bus-conflict error flag.
// - low enable pin never resets the unit; 3-pin mode ignores the pin.
// - 4-pin slave with enable pin high halts receive, releases in line.
// - high enable pin in slave mode only suspends, never resets.
// - reset sets the soft reset bit, holding the unit until software clears it.
// - soft reset clears interrupt enables, receive flag, errors; sets transmit flag.
// - master starts on buffer write, loads empty shift register, msb first.
// - master samples in line msb first, full character loads buffer, sets flag.
// - transmit flag sets when buffer moves to shift register.
// - master shows completion by transmitter-empty bit set to one.
// - slave shifts only on external clock; preloaded data goes out.
// - slave samples on opposite edge, full character loads buffer, sets flag.
// - overrun sets when a new character lands before the last was read.
// - module enable zero stops after current transfer, or at once when idle.
// - reset or soft reset aborts any transfer at once.
// - flag register bit 5 transmit flag resets one, bit 4 receive flag zero.
// - master clock comes from the divider; slave ignores the divider.
// - bit rate is source over 16-bit divisor, at most half the source.
// - clock polarity and phase are independent control bits.
// - transmit flag clears on interrupt service or buffer write.
`include "usp_cfg.svh"
`timescale 1ns/1ns
`default_nettype none

module usp_spi (
   // clock and reset
   input  wire logic         ref_clk,
   input  wire logic         rst_b,
   // apb slave
   input  wire logic [11:0]  paddr,
   input  wire logic         psel,
   input  wire logic         penable,
   input  wire logic         pwrite,
   input  wire logic [31:0]  pwdata,
   output var  logic [31:0]  prdata,
   output logic              pready,
   output logic              pslverr,
   // interrupt requests and service acknowledges
   output logic              tx_irq,
   output logic              rx_irq,
   input  wire logic         tx_irq_ack,
   input  wire logic         rx_irq_ack,
   // serial pins
   input  wire logic         master_out_line_i,
   output logic              master_out_line_o,
   output logic              master_out_line_oe,
   input  wire logic         master_in_line_i,
   output logic              master_in_line_o,
   output logic              master_in_line_oe,
   input  wire logic         serial_clock_pin_i,
   output logic              serial_clock_pin_o,
   output logic              serial_clock_pin_oe,
   input  wire logic         slave_transmit_enable_pin
);
   import usp_pkg::*;

   localparam usp_byte_t FLG_RST = `USP_FLG_RESET;

   function automatic logic [3:0] usp_nbits(input logic ch8);
      usp_nbits = ch8 ? 4'h8 : 4'h7;
   endfunction : usp_nbits

   function automatic usp_byte_t usp_mask(input logic ch8, input usp_byte_t v);
      usp_mask = ch8 ? v : {1'b0, v[6:0]};
   endfunction : usp_mask

   // register state
   logic [7:0]  ctrl_q,  ctrl_d;
   logic [2:0]  ena_q,   ena_d;
   logic        txflag_q, txflag_d;
   logic        rxflag_q, rxflag_d;
   logic        ovr_q,   ovr_d;
   logic        bce_q,   bce_d;
   logic [15:0] div_q,   div_d;
   usp_byte_t   txbuf_q, txbuf_d;
   logic        txfull_q, txfull_d;
   usp_byte_t   rxbuf_q, rxbuf_d;
   logic [31:0] prdata_q, prdata_d;
   // engine state
   usp_state_t  state_q, state_d;
   usp_byte_t   tx_sr_q, tx_sr_d;
   usp_byte_t   rx_sr_q, rx_sr_d;
   logic        srfull_q, srfull_d;
   logic [3:0]  bitcnt_q, bitcnt_d;
   logic [15:0] divcnt_q, divcnt_d;
   logic        sclk_act_q, sclk_act_d;
   logic        sclk_prev_q;

   logic        spi_mode, srst, run, ena, master, four, char8, pha, pol;
   logic        m_conflict, s_halt, busy, active;
   logic        wr, rd, setup, hit, load, done, sample, shift, lead, trail, din;
   logic [15:0] div_eff, half;
   logic [3:0]  nbits;
   usp_byte_t   rx_next, rx_final;

   assign spi_mode   = ctrl_q[`USP_CTL_SYNC] & ~ctrl_q[`USP_CTL_I2C];
   assign srst       = ctrl_q[`USP_CTL_SOFT_RESET_BIT];
   assign run        = spi_mode & ~srst;
   assign ena        = ena_q[`USP_ENA_ME];
   assign master     = ctrl_q[`USP_CTL_MM];
   assign four       = ctrl_q[`USP_CTL_FOUR];
   assign char8      = ctrl_q[`USP_CTL_CHAR];
   assign pha        = ctrl_q[`USP_CTL_PHA];
   assign pol        = ctrl_q[`USP_CTL_POL];
   assign nbits      = usp_nbits(char8);
   // the enable pin is only looked at in 4-pin mode and never resets state
   assign m_conflict = master & four & ~slave_transmit_enable_pin;
   assign s_halt     = ~master & four & slave_transmit_enable_pin;
   assign busy       = (state_q == USP_XFER);
   assign active     = run & (ena | busy);

   // zero-wait apb slave
   assign setup   = psel & ~penable;
   assign wr      = psel & penable & pwrite;
   assign rd      = psel & penable & ~pwrite;
   assign pready  = 1'b1;
   assign hit     = (paddr == `USP_OFF_CTRL) | (paddr == `USP_OFF_ENA) |
                    (paddr == `USP_OFF_FLAGS) | (paddr == `USP_OFF_STAT) |
                    (paddr == `USP_OFF_DIV) | (paddr == `USP_OFF_TXBUF) |
                    (paddr == `USP_OFF_RXBUF);
   assign pslverr = psel & penable & ~hit;
   assign prdata  = prdata_q;

   // bit clock from the divider, floor keeps it at or below half the source
   assign div_eff = (div_q < `USP_DIV_MIN) ? `USP_DIV_MIN : div_q;
   assign half    = div_eff >> 1;

   always_comb begin
      if (master) begin
         // master edges come from the divider only
         lead  = busy & ~m_conflict & (divcnt_q == half - 16'h0001);
         trail = busy & ~m_conflict & (divcnt_q == div_eff - 16'h0001);
      end else begin
         // slave edges come from the external clock only
         lead  = active & ~s_halt & (serial_clock_pin_i ^ pol) & ~sclk_prev_q;
         trail = active & ~s_halt & ~(serial_clock_pin_i ^ pol) & sclk_prev_q;
      end
   end

   assign sample   = pha ? trail : lead;
   // with the second phase the first leading edge only opens the bit
   assign shift    = (pha ? lead : trail) & ~(pha & (bitcnt_q == 4'h0));
   assign din      = master ? master_in_line_i : master_out_line_i;
   assign rx_next  = sample ? {rx_sr_q[6:0], din} : rx_sr_q;
   assign rx_final = usp_mask(char8, rx_next);
   assign done     = trail & (bitcnt_q == (pha ? nbits - 4'h1 : nbits));
   assign load     = run & ena & txfull_q & ~srfull_q &
                     (master ? ~busy & ~m_conflict : ~busy);

   // serial engine
   always_comb begin
      state_d    = state_q;
      tx_sr_d    = tx_sr_q;
      rx_sr_d    = rx_next;
      srfull_d   = srfull_q;
      bitcnt_d   = bitcnt_q;
      divcnt_d   = divcnt_q;
      sclk_act_d = sclk_act_q;
      if (load) begin
         tx_sr_d  = char8 ? txbuf_q : {txbuf_q[6:0], 1'b0};
         srfull_d = 1'b1;
         if (master) begin
            state_d  = USP_XFER;
            divcnt_d = 16'h0000;
            bitcnt_d = 4'h0;
         end
      end
      if (master) begin
         if (busy & ~m_conflict) begin
            divcnt_d = (divcnt_q == div_eff - 16'h0001) ? 16'h0000 : divcnt_q + 16'h0001;
         end
         if (lead) begin
            sclk_act_d = 1'b1;
         end
         if (trail) begin
            sclk_act_d = 1'b0;
         end
      end else if (~busy & (lead | trail)) begin
         state_d = USP_XFER;
      end
      if (sample) begin
         bitcnt_d = bitcnt_q + 4'h1;
      end
      if (shift) begin
         tx_sr_d = {tx_sr_q[6:0], 1'b0};
      end
      if (done) begin
         state_d  = USP_IDLE;
         bitcnt_d = 4'h0;
         srfull_d = 1'b0;
      end
      if (~master & s_halt) begin
         // receive in progress is dropped, nothing else is touched
         state_d  = USP_IDLE;
         bitcnt_d = 4'h0;
      end
      if (~run) begin
         state_d    = USP_IDLE;
         bitcnt_d   = 4'h0;
         divcnt_d   = 16'h0000;
         sclk_act_d = 1'b0;
         srfull_d   = 1'b0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         state_q     <= USP_IDLE;
         tx_sr_q     <= 8'h00;
         rx_sr_q     <= 8'h00;
         srfull_q    <= 1'b0;
         bitcnt_q    <= 4'h0;
         divcnt_q    <= 16'h0000;
         sclk_act_q  <= 1'b0;
         sclk_prev_q <= 1'b0;
      end else begin
         state_q     <= state_d;
         tx_sr_q     <= tx_sr_d;
         rx_sr_q     <= rx_sr_d;
         srfull_q    <= srfull_d;
         bitcnt_q    <= bitcnt_d;
         divcnt_q    <= divcnt_d;
         sclk_act_q  <= sclk_act_d;
         sclk_prev_q <= serial_clock_pin_i ^ pol;
      end
   end

   // registers; hardware sets are applied after software clears
   always_comb begin
      ctrl_d   = ctrl_q;
      ena_d    = ena_q;
      txflag_d = txflag_q;
      rxflag_d = rxflag_q;
      ovr_d    = ovr_q;
      bce_d    = bce_q;
      div_d    = div_q;
      txbuf_d  = txbuf_q;
      txfull_d = txfull_q;
      rxbuf_d  = rxbuf_q;
      prdata_d = prdata_q;
      if (setup) begin
         case (paddr)
            `USP_OFF_CTRL:  prdata_d = {24'h000000, ctrl_q};
            `USP_OFF_ENA:   prdata_d = {29'h00000000, ena_q};
            `USP_OFF_FLAGS: prdata_d = {26'h0000000, txflag_q, rxflag_q, 4'h0};
            `USP_OFF_STAT:  prdata_d = {29'h00000000, bce_q, ovr_q,
                                        ~busy & ~txfull_q & ~srfull_q};
            `USP_OFF_DIV:   prdata_d = {16'h0000, div_q};
            `USP_OFF_TXBUF: prdata_d = {24'h000000, txbuf_q};
            `USP_OFF_RXBUF: prdata_d = {24'h000000, rxbuf_q};
            default:        prdata_d = 32'h00000000;
         endcase
      end
      if (wr) begin
         case (paddr)
            `USP_OFF_CTRL:  ctrl_d = pwdata[7:0];
            `USP_OFF_ENA:   ena_d = pwdata[2:0];
            `USP_OFF_FLAGS: begin
               txflag_d = pwdata[`USP_FLG_TX];
               rxflag_d = pwdata[`USP_FLG_RX];
            end
            `USP_OFF_STAT: begin
               if (pwdata[`USP_STA_OVR]) begin
                  ovr_d = 1'b0;
               end
               if (pwdata[`USP_STA_BCE]) begin
                  bce_d = 1'b0;
               end
            end
            `USP_OFF_DIV:   div_d = pwdata[15:0];
            default: ;
         endcase
      end
      if (rd & (paddr == `USP_OFF_RXBUF)) begin
         rxflag_d = 1'b0;
         ovr_d    = 1'b0;
      end
      if (tx_irq_ack) begin
         txflag_d = 1'b0;
      end
      if (rx_irq_ack) begin
         rxflag_d = 1'b0;
      end
      if (load) begin
         txfull_d = 1'b0;
      end
      if (wr & (paddr == `USP_OFF_TXBUF)) begin
         txbuf_d  = usp_mask(char8, pwdata[7:0]);
         txfull_d = 1'b1;
         txflag_d = 1'b0;
      end
      if (load) begin
         txflag_d = 1'b1;
      end
      if (done) begin
         rxbuf_d  = rx_final;
         rxflag_d = 1'b1;
         if (rxflag_q) begin
            ovr_d = 1'b1;
         end
      end
      if (run & m_conflict) begin
         bce_d = 1'b1;
      end
      if (srst) begin
         ena_d[`USP_ENA_RXIE] = 1'b0;
         ena_d[`USP_ENA_TXIE] = 1'b0;
         rxflag_d = 1'b0;
         ovr_d    = 1'b0;
         bce_d    = 1'b0;
         txflag_d = 1'b1;
         txfull_d = 1'b0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         ctrl_q   <= `USP_CTL_RESET;
         ena_q    <= `USP_ENA_RESET;
         txflag_q <= FLG_RST[`USP_FLG_TX];
         rxflag_q <= 1'b0;
         ovr_q    <= 1'b0;
         bce_q    <= 1'b0;
         div_q    <= `USP_DIV_RESET;
         txbuf_q  <= 8'h00;
         txfull_q <= 1'b0;
         rxbuf_q  <= 8'h00;
         prdata_q <= 32'h00000000;
      end else begin
         ctrl_q   <= ctrl_d;
         ena_q    <= ena_d;
         txflag_q <= txflag_d;
         rxflag_q <= rxflag_d;
         ovr_q    <= ovr_d;
         bce_q    <= bce_d;
         div_q    <= div_d;
         txbuf_q  <= txbuf_d;
         txfull_q <= txfull_d;
         rxbuf_q  <= rxbuf_d;
         prdata_q <= prdata_d;
      end
   end

   // pins: drivers released in 4-pin conflict or slave deselect
   assign master_out_line_o   = tx_sr_q[7];
   assign master_in_line_o    = tx_sr_q[7];
   assign serial_clock_pin_o  = pol ^ sclk_act_q;
   assign master_out_line_oe  = active & master & ~m_conflict;
   assign serial_clock_pin_oe = active & master & ~m_conflict;
   assign master_in_line_oe   = active & ~master & ~s_halt;
   assign tx_irq = txflag_q & ena_q[`USP_ENA_TXIE];
   assign rx_irq = rxflag_q & ena_q[`USP_ENA_RXIE];

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_b);

   property p_mode_gate;
      !spi_mode |=> state_q == USP_IDLE;
   endproperty
   a_mode_gate: assert property (p_mode_gate) else $error("busy outside spi mode");

   property p_conflict_release;
      m_conflict |-> !master_out_line_oe && !serial_clock_pin_oe;
   endproperty
   a_conflict_release: assert property (p_conflict_release) else $error("drove in conflict");

   property p_conflict_flag;
      run && m_conflict ##1 !srst |-> bce_q;
   endproperty
   a_conflict_flag: assert property (p_conflict_flag) else $error("conflict flag missing");

   property p_slave_halt;
      s_halt && run |-> !master_in_line_oe ##1 bitcnt_q == 4'h0;
   endproperty
   a_slave_halt: assert property (p_slave_halt) else $error("slave not halted");

   property p_soft_reset;
      srst ##1 srst |-> txflag_q && !rxflag_q && !ovr_q && !bce_q && !busy;
   endproperty
   a_soft_reset: assert property (p_soft_reset) else $error("soft reset state wrong");

   property p_load;
      load && master |=> busy && txflag_q && tx_sr_q == $past(char8 ? txbuf_q
                                                     : {txbuf_q[6:0], 1'b0});
   endproperty
   a_load: assert property (p_load) else $error("load did not start transfer");

   property p_done;
      done && !srst |=> rxflag_q && rxbuf_q == $past(rx_final);
   endproperty
   a_done: assert property (p_done) else $error("character not delivered");

   property p_overrun;
      done && rxflag_q && !(rd && paddr == `USP_OFF_RXBUF) && !srst |=> ovr_q;
   endproperty
   a_overrun: assert property (p_overrun) else $error("overrun missed");

   property p_disable_idle;
      !ena && !busy |=> !busy [*2];
   endproperty
   a_disable_idle: assert property (p_disable_idle) else $error("started while off");

   property p_divcnt;
      master && busy |-> divcnt_q < div_eff && half >= 16'h0001;
   endproperty
   a_divcnt: assert property (p_divcnt) else $error("divider out of range");

   property p_txwrite;
      wr && paddr == `USP_OFF_TXBUF && !load && !srst |=> !txflag_q;
   endproperty
   a_txwrite: assert property (p_txwrite) else $error("flag kept after write");

   c_master_char: cover property (master && done);
   c_slave_char:  cover property (!master && done);
   c_overrun:     cover property (done && rxflag_q);
   c_conflict:    cover property (run && m_conflict);
endmodule : usp_spi

`default_nettype wire

// *** test/usp_partner.sv ***
`timescale 1ns/1ns
`default_nettype none

module usp_partner (
   // bench clock paces the master role
   input  wire logic ref_clk,
   input  wire logic act_master,
   // serial wires as resolved by the bench
   input  wire logic sck,
   input  wire logic mo,
   input  wire logic mi,
   output logic      data_o,
   output logic      sck_o
);
   logic [7:0] tx_q;
   logic [7:0] rx_q;
   logic       sck_q = 1'b0;

   // mode 0 in either role: sample on rising, next bit on falling
   always @(posedge sck) rx_q <= {rx_q[6:0], act_master ? mi : mo};
   // inverted refill, so a stale bit never repeats the last one
   always @(negedge sck) tx_q <= {tx_q[6:0], ~tx_q[0]};
   assign data_o = tx_q[7];
   assign sck_o  = sck_q;

   task automatic load(input logic [7:0] v);
      tx_q = v;
   endtask : load

   // clock stands low between frames; half period of 4 cycles
   task automatic clock_out(input int bits);
      repeat (bits) begin
         repeat (4) @(posedge ref_clk);
         sck_q <= 1'b1;
         repeat (4) @(posedge ref_clk);
         sck_q <= 1'b0;
      end
   endtask : clock_out
endmodule : usp_partner

`default_nettype wire

// *** test/usp_spi_test.sv ***
`include "usp_cfg.svh"
`timescale 1ns/1ns
`default_nettype none

module usp_spi_test;
   import usp_pkg::*;
   logic        ref_clk = 1'b0;
   logic        rst_b, psel, penable, pwrite, pready, pslverr, slverr;
   logic        tx_irq, rx_irq, tx_irq_ack, rx_irq_ack, flip, act_master;
   logic        slave_transmit_enable_pin;
   logic        mo_o, mo_oe, mi_o, mi_oe, sck_o, sck_oe, p_data, p_sck;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rdat;
   int          err_count, checks, sck_rises;
   time         sck_t, sck_gap;
   // undriven wires toggle so a released line never holds its last value
   wire logic   mo_w = mo_oe ? mo_o : (act_master ? p_data : flip);
   wire logic   mi_w = mi_oe ? mi_o : (act_master ? flip : p_data);
   wire logic   sck_w = sck_oe ? sck_o : (act_master ? p_sck : flip);
   wire logic   sck_drv = sck_oe & sck_o;

   usp_spi usp_spi_i (
      .ref_clk, .rst_b, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
      .pslverr, .tx_irq, .rx_irq, .tx_irq_ack, .rx_irq_ack,
      .master_out_line_i(mo_w), .master_out_line_o(mo_o), .master_out_line_oe(mo_oe),
      .master_in_line_i(mi_w), .master_in_line_o(mi_o), .master_in_line_oe(mi_oe),
      .serial_clock_pin_i(sck_w), .serial_clock_pin_o(sck_o), .serial_clock_pin_oe(sck_oe),
      .slave_transmit_enable_pin
   );
   usp_partner usp_partner_i (
      .ref_clk, .act_master, .sck(sck_w), .mo(mo_w), .mi(mi_w), .data_o(p_data), .sck_o(p_sck)
   );

   always #2 ref_clk = ~ref_clk;
   always @(posedge ref_clk) flip <= ~flip;
   // only edges the block itself drives are counted
   always @(posedge sck_drv) begin
      sck_rises++;
      sck_gap = $time - sck_t;
      sck_t = $time;
   end

   task automatic stop_test();
      if (err_count == 0 && checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : stop_test

   task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : cmp

   task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
      int n;
      n = 0;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      psel <= 1'b1;
      @(posedge ref_clk);
      penable <= 1'b1;
      @(posedge ref_clk);
      while (pready !== 1'b1 && n < 64) begin
         n++;
         @(posedge ref_clk);
      end
      if (n >= 64) err_count++;
      rdat = prdata;
      slverr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge ref_clk);
   endtask : apb

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(a, 1'b1, d);
   endtask : wr

   task automatic rd_cmp(input logic [11:0] a, input logic [31:0] e, input string what);
      apb(a, 1'b0, 32'h0);
      cmp(what, e, rdat);
   endtask : rd_cmp

   task automatic wait_bit(input logic [11:0] a, input int b);
      int n;
      n = 0;
      rdat = '0;
      while (rdat[b] !== 1'b1 && n < 100) begin
         apb(a, 1'b0, 32'h0);
         n++;
      end
      if (rdat[b] !== 1'b1) err_count++;
   endtask : wait_bit

   task automatic cfg(input logic [7:0] c, input logic [2:0] e);
      wr(`USP_OFF_CTRL, {24'h0, c | 8'h01});
      wr(`USP_OFF_DIV, 32'h4);
      wr(`USP_OFF_ENA, {29'h0, e});
      wr(`USP_OFF_CTRL, {24'h0, c});
   endtask : cfg

   task automatic t_reset();
      rd_cmp(`USP_OFF_CTRL, 32'h1, "ctrl");
      rd_cmp(`USP_OFF_FLAGS, 32'h20, "flags");
      rd_cmp(`USP_OFF_ENA, 32'h0, "ena");
      rd_cmp(`USP_OFF_STAT, 32'h1, "stat");
      rd_cmp(`USP_OFF_DIV, 32'h2, "div");
      rd_cmp(12'h01C, 32'h0, "unmapped");
      cmp("slverr", 32'h1, {31'h0, slverr});
      cmp("oe", 32'h0, {29'h0, mo_oe, mi_oe, sck_oe});
   endtask : t_reset

   task automatic t_master();
      cfg(8'h16, 3'h1);
      usp_partner_i.load(8'hA5);
      sck_rises = 0;
      wr(`USP_OFF_TXBUF, 32'h3C);
      rd_cmp(`USP_OFF_FLAGS, 32'h20, "tx flag");
      rd_cmp(`USP_OFF_STAT, 32'h0, "busy");
      wait_bit(`USP_OFF_FLAGS, 4);
      cmp("rx flag", 32'h30, rdat);
      rd_cmp(`USP_OFF_STAT, 32'h1, "empty");
      cmp("rises", 32'h8, sck_rises);
      cmp("period", 32'h10, 32'(sck_gap));
      cmp("sent", 32'h3C, {24'h0, usp_partner_i.rx_q});
      // the buffer is left unread so the next character overruns it
      wr(`USP_OFF_TXBUF, 32'h77);
      wait_bit(`USP_OFF_STAT, 0);
      rd_cmp(`USP_OFF_STAT, 32'h3, "overrun");
      rd_cmp(`USP_OFF_RXBUF, 32'h55, "rx data");
      rd_cmp(`USP_OFF_STAT, 32'h1, "overrun clear");
      rd_cmp(`USP_OFF_FLAGS, 32'h20, "rx clear");
   endtask : t_master

   task automatic t_seven();
      cfg(8'h06, 3'h1);
      usp_partner_i.load(8'hB4);
      sck_rises = 0;
      wr(`USP_OFF_TXBUF, 32'hDA);
      wait_bit(`USP_OFF_FLAGS, 4);
      rd_cmp(`USP_OFF_RXBUF, 32'h5A, "rx7");
      cmp("sent7", 32'h5A, {25'h0, usp_partner_i.rx_q[6:0]});
      cmp("rises7", 32'h7, sck_rises);
   endtask : t_seven

   task automatic t_pins();
      cfg(8'h36, 3'h1);
      cmp("drive", 32'h3, {30'h0, mo_oe, sck_oe});
      slave_transmit_enable_pin <= 1'b0;
      repeat (2) @(posedge ref_clk);
      cmp("release", 32'h0, {30'h0, mo_oe, sck_oe});
      rd_cmp(`USP_OFF_STAT, 32'h5, "conflict");
      slave_transmit_enable_pin <= 1'b1;
      rd_cmp(`USP_OFF_CTRL, 32'h36, "no reset");
      wr(`USP_OFF_STAT, 32'h4);
      slave_transmit_enable_pin <= 1'b0;
      cfg(8'h16, 3'h1);
      rd_cmp(`USP_OFF_STAT, 32'h1, "three pin");
      cmp("drive3", 32'h3, {30'h0, mo_oe, sck_oe});
      slave_transmit_enable_pin <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         cfg({i[1:0], 6'h16}, 3'h1);
         cmp("idle level", {31'h0, i[0]}, {31'h0, sck_o});
      end
   endtask : t_pins

   task automatic t_slave();
      act_master <= 1'b1;
      cfg(8'h34, 3'h1);
      slave_transmit_enable_pin <= 1'b0;
      usp_partner_i.load(8'h69);
      wr(`USP_OFF_TXBUF, 32'h96);
      cmp("slave oe", 32'h2, {30'h0, mi_oe, sck_oe});
      usp_partner_i.clock_out(8);
      repeat (4) @(posedge ref_clk);
      rd_cmp(`USP_OFF_RXBUF, 32'h69, "slave rx");
      cmp("slave tx", 32'h96, {24'h0, usp_partner_i.rx_q});
      slave_transmit_enable_pin <= 1'b1;
      usp_partner_i.clock_out(8);
      cmp("slave release", 32'h0, {31'h0, mi_oe});
      rd_cmp(`USP_OFF_FLAGS, 32'h20, "halted");
      rd_cmp(`USP_OFF_CTRL, 32'h34, "slave kept");
      act_master <= 1'b0;
   endtask : t_slave

   task automatic t_irq_abort();
      cfg(8'h16, 3'h1);
      wr(`USP_OFF_ENA, 32'h7);
      cmp("tx irq", 32'h1, {31'h0, tx_irq});
      wr(`USP_OFF_FLAGS, 32'h30);
      cmp("rx irq", 32'h1, {31'h0, rx_irq});
      tx_irq_ack <= 1'b1;
      rx_irq_ack <= 1'b1;
      @(posedge ref_clk);
      tx_irq_ack <= 1'b0;
      rx_irq_ack <= 1'b0;
      rd_cmp(`USP_OFF_FLAGS, 32'h0, "ack");
      cmp("irq off", 32'h0, {30'h0, tx_irq, rx_irq});
      sck_rises = 0;
      wr(`USP_OFF_TXBUF, 32'hC3);
      wr(`USP_OFF_CTRL, 32'h17);
      repeat (40) @(posedge ref_clk);
      cmp("aborted", 32'h1, {31'h0, sck_rises < 2});
      rd_cmp(`USP_OFF_FLAGS, 32'h20, "sw flags");
      rd_cmp(`USP_OFF_ENA, 32'h1, "sw ena");
      cmp("irqs", 32'h0, {30'h0, tx_irq, rx_irq});
   endtask : t_irq_abort

   task automatic t_enable();
      cfg(8'h16, 3'h1);
      usp_partner_i.load(8'h0F);
      sck_rises = 0;
      wr(`USP_OFF_TXBUF, 32'hF0);
      wr(`USP_OFF_ENA, 32'h0);
      wait_bit(`USP_OFF_FLAGS, 4);
      cmp("finish", 32'h8, sck_rises);
      rd_cmp(`USP_OFF_RXBUF, 32'h0F, "finish data");
      // disabled unit, then a two-wire selection: neither may shift
      for (int i = 0; i < 2; i++) begin
         cfg(i ? 8'h1E : 8'h16, {2'h0, i[0]});
         sck_rises = 0;
         wr(`USP_OFF_TXBUF, 32'h55);
         repeat (40) @(posedge ref_clk);
         cmp("no shift", 32'h0, sck_rises);
         rd_cmp(`USP_OFF_FLAGS, 32'h0, "no load");
      end
   endtask : t_enable

   initial begin
      {rst_b, psel, penable, pwrite, tx_irq_ack, rx_irq_ack, act_master, flip} = '0;
      slave_transmit_enable_pin = 1'b1;
      paddr = '0;
      pwdata = '0;
      repeat (5) @(posedge ref_clk);
      rst_b <= 1'b1;
      @(posedge ref_clk);
      t_reset();
      t_master();
      t_seven();
      t_pins();
      t_slave();
      t_irq_abort();
      t_enable();
      stop_test();
   end

   initial begin
      repeat (30000) @(posedge ref_clk);
      err_count++;
      stop_test();
   end
endmodule : usp_spi_test

`default_nettype wire
